// file: logic/afr_params.svh
// afr_params.svh - offsets, opcodes, reset values and timing counts
// assumes inclusion by bare name from afr design files
`ifndef AFR_PARAMS_SVH
`define AFR_PARAMS_SVH

// --------------------------------------------------------------
// command opcodes on the serial link
// --------------------------------------------------------------
`define AFR_OP_WAKE 8'h00
`define AFR_OP_SYNC 8'h04
`define AFR_OP_RESET 8'h06
`define AFR_OP_RDATA 8'h12
`define AFR_OP_OCAL 8'h62
`define AFR_OP_REGISTER_WRITE_COMMAND_HI 4'h4
`define AFR_SYNC_FIRST7 7'h02

// --------------------------------------------------------------
// device register indices and reset values
// --------------------------------------------------------------
`define AFR_REG_INSEL 4'h0
`define AFR_REG_BIAS 4'h1
`define AFR_REG_REFMON 4'h2
`define AFR_REG_GAINRATE 4'h3
`define AFR_REG_OFC0 4'h4
`define AFR_REG_FSC0 4'h7
`define AFR_NREGS 10
`define AFR_FSC_RESET 24'h400000
`define AFR_FSC_SHIFT 22
`define AFR_RATE_MAX 4'h9

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define AFR_SYNC_DELAY 3'h4
`define AFR_FILT_HOLD_MOD 32
`define AFR_SYS_PERIOD_NS 8
`define AFR_OSC_KHZ 4096
`define AFR_SCLK_MAX_NS 520
`define AFR_BYTE_SPACE_NS 4200
`define AFR_REGISTER_WRITE_COMMAND_GAP_OSC 64

// --------------------------------------------------------------
// host command port addresses
// --------------------------------------------------------------
`define AFR_H_CMD 2'h0
`define AFR_H_REGISTER_WRITE_COMMAND 2'h1
`define AFR_H_PINS 2'h2
`define AFR_H_STAT 2'h0
`define AFR_H_DATA 2'h1

`endif

// file: logic/afr_pkg.sv
// afr_pkg.sv - state types shared by both ends of the converter link
// assumes nothing beyond a SystemVerilog compiler
package afr_pkg;
    // device serial parser states, gray along command -> count -> data
    typedef enum logic [1:0] {
        RX_CMD = 2'h0,
        RX_CNT = 2'h1,
        RX_DATA = 2'h3,
        RX_RD = 2'h2
    } afr_rx_t;

    // host frame states
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_SHIFT = 2'h1,
        H_GAP = 2'h3
    } afr_host_t;
endpackage

// file: logic/afr_link_if.sv
// afr_link_if.sv - serial link and control pins between host and converter
// assumes the host makes sclk; all wires are single-driver
`timescale 1ns/10ps
interface afr_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic start;
    logic reset_pin_n;
    logic conversion_ready_n;

    modport device (
        input sclk, cs_n, mosi, start, reset_pin_n,
        output miso, conversion_ready_n
    );
    modport host (
        output sclk, cs_n, mosi, start, reset_pin_n,
        input miso, conversion_ready_n
    );
endinterface

// file: logic/afr_device.sv
// afr_device.sv - converter end: register writes, filter reset, conversion
// timing, offset/gain scaling with clipping, serial command decode
// assumes link pins are asynchronous to sys_clk; filter_data is on sys_clk
`timescale 1ns/10ps
`include "afr_params.svh"

// Overview of operation
// - first result after start is fully settled
// - each register byte applies at its end
// - host keeps sclk and byte spacing fast
// - host waits 64 oscillator clocks between writes
// - listed writes, resync, start rise reset filter
// - resync resets four clocks after seventh fall
// - input select write resets filter on completion
// - other setup writes hold reset 32 modulator clocks
// - overlapping reset pulses combine, reset while any
// - short first length after resync, input write or calibration
// - long first length after other reset causes
// - later conversions use fixed per-rate length
// - subtract offset top, multiply gain over 400000h
// - saturate scaled output to sixteen bits
// - corrections load by write, offset also by calibration
// - host bounds large gain with offset
// - host clears overload before changing rate
// - host writes gain/rate before input select
// - host may rewrite input select alone
// - setup register writes restart like start rise
// - conversion end drives ready output low
module afr_device #(
    parameter int CLK_DIV = 30,
    parameter int MOD_DIV = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link to host
    afr_link_if.device link,
    // user side
    input wire logic [15:0] filter_data,
    output logic [15:0] result,
    output logic result_valid,
    output logic filter_reset
);
    // ----------------------------------------------------------
    // constants and checks
    // ----------------------------------------------------------
    localparam int HOLD = `AFR_FILT_HOLD_MOD * MOD_DIV;
    localparam logic [79:0] CFG_RST = {`AFR_FSC_RESET, 56'h0};
    localparam logic [4:0] PIN_IDLE = 5'h12;
    localparam logic [19:0] LEN_SHORT [10] = '{20'd816160, 20'd408096,
        20'd204064, 20'd102072, 20'd51064, 20'd25560, 20'd12796,
        20'd6428, 20'd4156, 20'd2108};
    localparam logic [19:0] LEN_LONG [10] = '{20'd820265, 20'd412201,
        20'd208169, 20'd103106, 20'd52098, 20'd26594, 20'd13314,
        20'd6946, 20'd4674, 20'd2370};
    localparam logic [19:0] LEN_NEXT [10] = '{20'd816128, 20'd408064,
        20'd204032, 20'd102016, 20'd51008, 20'd25504, 20'd12736,
        20'd6368, 20'd4096, 20'd2048};

    if (CLK_DIV < 1 || CLK_DIV > 65535 || MOD_DIV < 1 || HOLD > 65535) begin : g_chk
        $error("afr_device: divider out of range");
    end

    // ----------------------------------------------------------
    // pin synchronisers: {reset, start, mosi, cs_n, sclk}
    // ----------------------------------------------------------
    logic [4:0] pin_s1, pin_s2, pin_s3, pin_q;
    logic sclk_d, start_d;

    // three flops, a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
            pin_s3 <= PIN_IDLE;
            pin_q <= PIN_IDLE;
            sclk_d <= 1'b0;
            start_d <= 1'b0;
        end else begin
            pin_s1 <= {link.reset_pin_n, link.start, link.mosi, link.cs_n, link.sclk};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_q <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
            sclk_d <= pin_q[0];
            start_d <= pin_q[3];
        end
    end

    logic sclk_fall, sclk_rise, cs_idle, start_hi, start_rise, pin_rst;
    assign sclk_fall = sclk_d & ~pin_q[0];
    assign sclk_rise = ~sclk_d & pin_q[0];
    assign cs_idle = pin_q[1];
    assign start_hi = pin_q[3];
    assign start_rise = ~start_d & pin_q[3];
    assign pin_rst = ~pin_q[4];

    // ----------------------------------------------------------
    // converter clock tick
    // ----------------------------------------------------------
    logic [15:0] div_cnt;
    logic tick;

    // one-cycle enable at the converter system clock rate
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= 16'h0;
            tick <= 1'b0;
        end else begin
            tick <= (div_cnt == 16'(CLK_DIV - 1));
            div_cnt <= (div_cnt == 16'(CLK_DIV - 1)) ? 16'h0 : div_cnt + 16'h1;
        end
    end

    // ----------------------------------------------------------
    // serial command parser
    // ----------------------------------------------------------
    afr_pkg::afr_rx_t rx_st;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic [3:0] wr_idx, wr_left, rd_cnt;
    logic [7:0] nb;
    logic byte_done, cmd_byte, wr_byte, rd_end;
    assign nb = {sh[6:0], pin_q[2]};
    assign byte_done = sclk_fall & ~cs_idle & (bit_cnt == 3'h7);
    assign cmd_byte = byte_done & (rx_st == afr_pkg::RX_CMD);
    assign wr_byte = byte_done & (rx_st == afr_pkg::RX_DATA);
    assign rd_end = sclk_fall & ~cs_idle & (rx_st == afr_pkg::RX_RD) & (rd_cnt == 4'hf);

    // bytes in msb first, sampled on falling sclk
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_st <= afr_pkg::RX_CMD;
            bit_cnt <= 3'h0;
            sh <= 8'h0;
            wr_idx <= 4'h0;
            wr_left <= 4'h0;
            rd_cnt <= 4'h0;
        end else if (cs_idle) begin
            rx_st <= afr_pkg::RX_CMD;
            bit_cnt <= 3'h0;
        end else if (sclk_fall) begin
            sh <= nb;
            bit_cnt <= bit_cnt + 3'h1;
            if (rx_st == afr_pkg::RX_RD) begin
                rd_cnt <= rd_cnt + 4'h1;
                if (rd_cnt == 4'hf) begin
                    rx_st <= afr_pkg::RX_CMD;
                    bit_cnt <= 3'h0;
                end
            end else if (bit_cnt == 3'h7) begin
                case (rx_st)
                    afr_pkg::RX_CMD: begin
                        if (nb[7:4] == `AFR_OP_REGISTER_WRITE_COMMAND_HI) begin
                            wr_idx <= nb[3:0];
                            rx_st <= afr_pkg::RX_CNT;
                        end else if (nb == `AFR_OP_RDATA) begin
                            rd_cnt <= 4'h0;
                            rx_st <= afr_pkg::RX_RD;
                        end
                    end
                    afr_pkg::RX_CNT: begin
                        wr_left <= nb[3:0];
                        rx_st <= afr_pkg::RX_DATA;
                    end
                    default: begin
                        wr_idx <= wr_idx + 4'h1;
                        wr_left <= wr_left - 4'h1;
                        if (wr_left == 4'h0) rx_st <= afr_pkg::RX_CMD;
                    end
                endcase
            end
        end
    end

    logic sync7, wake_ev, soft_rst, ocal_ev;
    assign sync7 = sclk_fall & ~cs_idle & (rx_st == afr_pkg::RX_CMD) & (bit_cnt == 3'h6)
        & ({sh[5:0], pin_q[2]} == `AFR_SYNC_FIRST7);
    assign wake_ev = cmd_byte & (nb == `AFR_OP_WAKE);
    assign ocal_ev = cmd_byte & (nb == `AFR_OP_OCAL);
    assign soft_rst = pin_rst | (cmd_byte & (nb == `AFR_OP_RESET));

    // ----------------------------------------------------------
    // register file
    // ----------------------------------------------------------
    logic [7:0] cfg [`AFR_NREGS];
    logic ocal_load;
    logic [23:0] ocal_val;
    assign ocal_val = {filter_data, 8'h00};

    for (genvar g = 0; g < `AFR_NREGS; g++) begin : g_reg
        // each byte takes effect as soon as it is complete
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                cfg[g] <= CFG_RST[8*g +: 8];
            end else if (soft_rst) begin
                cfg[g] <= CFG_RST[8*g +: 8];
            end else if (wr_byte && wr_idx == 4'(g)) begin
                cfg[g] <= nb;
            end else if (ocal_load && g >= `AFR_REG_OFC0 && g < `AFR_REG_OFC0 + 3) begin
                cfg[g] <= ocal_val[8*((g - `AFR_REG_OFC0) % 3) +: 8];
            end
        end
    end

    // ----------------------------------------------------------
    // filter reset sources
    // ----------------------------------------------------------
    logic [2:0] sync_cnt;
    logic [15:0] hold_cnt;
    logic sync_fire, short_ev, long_ev, first_long;
    logic setup_wr;
    assign sync_fire = tick & (sync_cnt == 3'h1);
    assign setup_wr = wr_byte & (wr_idx >= `AFR_REG_BIAS) & (wr_idx <= `AFR_REG_GAINRATE);
    assign short_ev = sync_fire | ocal_ev | (wr_byte & (wr_idx == `AFR_REG_INSEL));
    assign long_ev = setup_wr | start_rise | wake_ev | soft_rst;

    // resync counts converter clocks after the seventh falling edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync_cnt <= 3'h0;
        end else if (sync7) begin
            sync_cnt <= `AFR_SYNC_DELAY;
        end else if (tick && sync_cnt != 3'h0) begin
            sync_cnt <= sync_cnt - 3'h1;
        end
    end

    // a fresh pulse reloads to full length, so overlaps merge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt <= 16'(HOLD);
            first_long <= 1'b1;
        end else begin
            if (long_ev) begin
                hold_cnt <= 16'(HOLD);
            end else if (tick && hold_cnt != 16'h0) begin
                hold_cnt <= hold_cnt - 16'h1;
            end
            if (long_ev) begin
                first_long <= 1'b1;
            end else if (short_ev && hold_cnt == 16'h0) begin
                first_long <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------
    // conversion length counter
    // ----------------------------------------------------------
    logic [3:0] rate;
    logic [19:0] conv_cnt, conv_len;
    logic first, in_reset, conv_done;
    assign rate = (cfg[`AFR_REG_GAINRATE][3:0] > `AFR_RATE_MAX) ? `AFR_RATE_MAX
        : cfg[`AFR_REG_GAINRATE][3:0];
    assign conv_len = !first ? LEN_NEXT[rate]
        : (first_long ? LEN_LONG[rate] : LEN_SHORT[rate]);
    assign in_reset = short_ev | long_ev | (hold_cnt != 16'h0) | ~start_hi;
    assign conv_done = tick & ~in_reset & (conv_cnt == conv_len - 20'h1);

    // any filter reset drops the running conversion
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            conv_cnt <= 20'h0;
            first <= 1'b1;
        end else if (in_reset) begin
            conv_cnt <= 20'h0;
            first <= 1'b1;
        end else if (tick) begin
            conv_cnt <= conv_done ? 20'h0 : conv_cnt + 20'h1;
            if (conv_done) first <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // offset and gain scaling
    // ----------------------------------------------------------
    logic [23:0] offset_correction, gain_correction;
    logic signed [16:0] diff;
    logic signed [41:0] prod, scaled;
    logic [15:0] clipped;
    assign offset_correction = {cfg[`AFR_REG_OFC0 + 2], cfg[`AFR_REG_OFC0 + 1], cfg[`AFR_REG_OFC0]};
    assign gain_correction = {cfg[`AFR_REG_FSC0 + 2], cfg[`AFR_REG_FSC0 + 1], cfg[`AFR_REG_FSC0]};
    assign diff = $signed({filter_data[15], filter_data}) - $signed({offset_correction[23], offset_correction[23:8]});
    assign prod = 42'(diff) * $signed({18'h0, gain_correction});
    assign scaled = prod >>> `AFR_FSC_SHIFT;
    assign clipped = (scaled > 42'sd32767) ? 16'h7fff
        : (scaled < -42'sd32768) ? 16'h8000 : scaled[15:0];

    // ----------------------------------------------------------
    // result, ready and readout
    // ----------------------------------------------------------
    logic ocal_pend;
    logic [15:0] tx;
    assign ocal_load = conv_done & ocal_pend;

    // offset calibration takes the next finished raw value
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) ocal_pend <= 1'b0;
        else if (ocal_ev) ocal_pend <= 1'b1;
        else if (conv_done || soft_rst) ocal_pend <= 1'b0;
    end

    // each full-length conversion yields settled data
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            result <= 16'h0;
            result_valid <= 1'b0;
            filter_reset <= 1'b1;
            link.conversion_ready_n <= 1'b1;
        end else begin
            result_valid <= conv_done;
            filter_reset <= in_reset;
            if (conv_done) begin
                result <= clipped;
                link.conversion_ready_n <= 1'b0;
            end else if (rd_end || soft_rst) begin
                link.conversion_ready_n <= 1'b1;
            end
        end
    end

    // read data shifted out msb first on rising sclk
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx <= 16'h0;
            link.miso <= 1'b0;
        end else if (cmd_byte && nb == `AFR_OP_RDATA) begin
            tx <= result;
        end else if (sclk_rise && rx_st == afr_pkg::RX_RD) begin
            link.miso <= tx[15];
            tx <= {tx[14:0], 1'b0};
        end
    end
endmodule

// file: logic/afr_host.sv
// afr_host.sv - host end: frames commands and register writes on the link
// assumes a software port on sys_clk; sclk made here by a divider
`timescale 1ns/10ps
`include "afr_params.svh"

module afr_host #(
    parameter int HALF = 10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // software port
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // link to converter
    afr_link_if.host link
);
    // ----------------------------------------------------------
    // timing
    // ----------------------------------------------------------
    localparam int OSC_DEN = `AFR_OSC_KHZ * `AFR_SYS_PERIOD_NS;
    localparam int GAP_CYC = (`AFR_REGISTER_WRITE_COMMAND_GAP_OSC * 1000000 + OSC_DEN - 1) / OSC_DEN;

    // sclk period and byte spacing kept inside the 2 kSPS bounds
    if (HALF < 4 || 2 * HALF * `AFR_SYS_PERIOD_NS > `AFR_SCLK_MAX_NS
        || 16 * HALF * `AFR_SYS_PERIOD_NS > `AFR_BYTE_SPACE_NS) begin : g_chk
        $error("afr_host: HALF out of range");
    end

    // ----------------------------------------------------------
    // input sync for miso and ready
    // ----------------------------------------------------------
    logic [1:0] in_s1, in_s2, in_s3, in_q;

    // three flops, a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            in_s1 <= 2'h2;
            in_s2 <= 2'h2;
            in_s3 <= 2'h2;
            in_q <= 2'h2;
        end else begin
            in_s1 <= {link.conversion_ready_n, link.miso};
            in_s2 <= in_s1;
            in_s3 <= in_s2;
            in_q <= (in_s2 & in_s3) | (in_q & (in_s2 ^ in_s3));
        end
    end

    // ----------------------------------------------------------
    // frame engine
    // ----------------------------------------------------------
    afr_pkg::afr_host_t st;
    logic [23:0] txsh;
    logic [15:0] rxsh, last_rd;
    logic [4:0] bit_cnt, nbits;
    logic [15:0] ph_cnt;
    logic need_gap;
    logic busy;
    assign busy = (st != afr_pkg::H_IDLE);

    // one register per frame, gap after each write
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st <= afr_pkg::H_IDLE;
            txsh <= 24'h0;
            rxsh <= 16'h0;
            last_rd <= 16'h0;
            bit_cnt <= 5'h0;
            nbits <= 5'h8;
            ph_cnt <= 16'h0;
            need_gap <= 1'b0;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.mosi <= 1'b0;
        end else begin
            case (st)
                afr_pkg::H_IDLE: begin
                    ph_cnt <= 16'h0;
                    bit_cnt <= 5'h0;
                    if (wr && addr == `AFR_H_CMD) begin
                        txsh <= {wdata[7:0], 16'h0};
                        nbits <= (wdata[7:0] == `AFR_OP_RDATA) ? 5'd24 : 5'd8;
                        need_gap <= 1'b0;
                        link.cs_n <= 1'b0;
                        st <= afr_pkg::H_SHIFT;
                    end else if (wr && addr == `AFR_H_REGISTER_WRITE_COMMAND) begin
                        txsh <= {`AFR_OP_REGISTER_WRITE_COMMAND_HI, wdata[11:8], 8'h00, wdata[7:0]};
                        nbits <= 5'd24;
                        need_gap <= 1'b1;
                        link.cs_n <= 1'b0;
                        st <= afr_pkg::H_SHIFT;
                    end
                end
                afr_pkg::H_SHIFT: begin
                    if (ph_cnt == 16'(HALF - 1)) begin
                        ph_cnt <= 16'h0;
                        link.sclk <= ~link.sclk;
                        if (!link.sclk) begin
                            link.mosi <= txsh[23];
                            txsh <= {txsh[22:0], 1'b0};
                        end else begin
                            rxsh <= {rxsh[14:0], in_q[0]};
                            bit_cnt <= bit_cnt + 5'h1;
                            if (bit_cnt == nbits - 5'h1) begin
                                st <= afr_pkg::H_GAP;
                            end
                        end
                    end else begin
                        ph_cnt <= ph_cnt + 16'h1;
                    end
                end
                default: begin
                    link.cs_n <= 1'b1; // one cycle after last fall, byte seen in frame
                    if (ph_cnt == 16'h0 && bit_cnt != 5'h0) begin
                        last_rd <= rxsh;
                        bit_cnt <= 5'h0;
                    end
                    ph_cnt <= ph_cnt + 16'h1;
                    if (ph_cnt >= (need_gap ? 16'(GAP_CYC) : 16'(HALF))) begin
                        st <= afr_pkg::H_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // pins and software reads
    // ----------------------------------------------------------
    // start and reset pins follow the pin register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            link.start <= 1'b0;
            link.reset_pin_n <= 1'b1;
        end else if (wr && addr == `AFR_H_PINS) begin
            link.start <= wdata[0];
            link.reset_pin_n <= ~wdata[1];
        end
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 16'h0;
        end else if (rd && addr == `AFR_H_STAT) begin
            rdata <= {14'h0, ~in_q[1], busy};
        end else if (rd && addr == `AFR_H_DATA) begin
            rdata <= last_rd;
        end else begin
            rdata <= 16'h0;
        end
    end
endmodule

// file: sim/afr_link_asserts.sv
// afr_link_asserts.sv - timing checks on the converter link
// assumes all link signals are sampled on sys_clk
`timescale 1ns/10ps
module afr_link_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic reset_pin_n,
    input wire logic conversion_ready_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // frame edges
    sequence s_open; $fell(cs_n); endsequence
    sequence s_close; $rose(cs_n); endsequence
    a_sclk_fast: assert property ($rose(sclk) |-> ##[1:32] $fell(sclk))
        else $error("sclk high too long");
    a_sclk_framed: assert property ($rose(sclk) |-> !cs_n)
        else $error("sclk outside frame");
    a_open_low: assert property (s_open |-> !sclk)
        else $error("frame opens with sclk high");
    a_frame_long: assert property (s_open |=> !cs_n[*8])
        else $error("frame too short");
    a_frame_gap: assert property (s_close |=> cs_n[*8])
        else $error("gap too short");
    a_mosi_held: assert property ($fell(sclk) |-> $stable(mosi))
        else $error("mosi moved at sample");
    a_idle_release: assert property ($rose(resetn) |-> cs_n && !sclk && conversion_ready_n)
        else $error("link not idle after reset");
    a_ready_held: assert property (!conversion_ready_n && cs_n
        && $past(cs_n, 8) && $past(reset_pin_n, 3) && $past(reset_pin_n, 4)
        |=> !conversion_ready_n)
        else $error("ready dropped without read");
endmodule

// file: sim/adc_filter_reset_and_scaling_tb_top.sv
// tb top - host and device joined, software port driven by tasks
// assumes shortened converter clocks: one tick per sys_clk
`timescale 1ns/10ps
module adc_filter_reset_and_scaling_tb_top;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] filter_data = 16'h1000;
    logic [15:0] rdata;
    logic [15:0] result;
    logic [15:0] s;
    logic result_valid;
    logic filter_reset;
    int mismatches = 0;
    int n_compared = 0;
    int since = 0;
    int gap = 0;
    int last = 0;
    int lastgap = 0;
    afr_link_if link ();
    afr_device #(.CLK_DIV(1), .MOD_DIV(1)) afr_device_inst (.sys_clk(sys_clk),
        .resetn(resetn), .link(link), .filter_data(filter_data), .result(result),
        .result_valid(result_valid), .filter_reset(filter_reset));
    afr_host afr_host_inst (.sys_clk(sys_clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
    afr_link_asserts afr_link_asserts_inst (.sys_clk(sys_clk), .resetn(resetn),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
        .reset_pin_n(link.reset_pin_n), .conversion_ready_n(link.conversion_ready_n));
    // clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    // cycles since filter restart and between results
    always @(posedge sys_clk) begin
        since <= filter_reset ? 0 : since + 1;
        gap <= result_valid ? 0 : gap + 1;
        if (result_valid) begin
            last <= since;
            lastgap <= gap + 1;
        end
    end
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol);
        n_compared++;
        if ($isunknown(got) || (tol == 0 ? got !== exp
            : (got > exp + tol || got + tol < exp))) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic get(input logic [1:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        s = rdata;
    endtask
    // bounded poll of host busy, then result pulse
    task automatic idle();
        for (int i = 0; i < 2000; i++) begin
            get(2'h0);
            if (s[0] === 1'b0) return;
        end
        mismatches++;
        final_report();
    endtask
    task automatic wait_valid();
        for (int i = 0; i < 4000; i++) begin
            @(negedge sys_clk);
            if (result_valid === 1'b1) begin
                @(negedge sys_clk);
                return;
            end
        end
        mismatches++;
        final_report();
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        put(2'h1, 16'h0309);
        idle();
        put(2'h2, 16'h0001);
        wait_valid();
        check(last, 2370, 40);
        wait_valid();
        check(lastgap, 2048, 1);
        check(link.conversion_ready_n, 1'b0, 0);
        put(2'h1, 16'h0001);
        wait_valid();
        check(last, 2108, 40);
        idle();
        wait_valid();
        put(2'h0, 16'h0004);
        wait_valid();
        check(last, 2108, 40);
        idle();
        wait_valid();
        put(2'h1, 16'h0100);
        wait_valid();
        check(last, 2370, 40);
        idle();
        put(2'h1, 16'h0510);
        idle();
        wait_valid();
        check(result, 16'h0ff0, 0);
        put(2'h1, 16'h0980);
        idle();
        wait_valid();
        check(result, 16'h1fe0, 0);
        @(posedge sys_clk);
        filter_data <= 16'h7000;
        wait_valid();
        check(result, 16'h7fff, 0);
        @(posedge sys_clk);
        filter_data <= 16'h9000;
        wait_valid();
        check(result, 16'h8000, 0);
        put(2'h0, 16'h0012);
        idle();
        get(2'h1);
        check(s, 16'h8000, 0);
        check(link.conversion_ready_n, 1'b1, 0);
        put(2'h2, 16'h0003);
        put(2'h2, 16'h0001);
        put(2'h1, 16'h0309); // rate back after register reset
        wait_valid();
        check(last, 2370, 40);
        wait_valid();
        check(result, 16'h9000, 0);
        put(2'h0, 16'h0000);
        wait_valid();
        check(last, 2370, 40);
        put(2'h0, 16'h0062);
        wait_valid();
        wait_valid();
        check(result, 16'h0000, 0);
        final_report();
    end
endmodule
